//--- pkg/sfs_consts.vh
/*
 * constants for the serial flash status read block: command code,
 * status byte field positions, reset values of the pin drivers.
 * assumes inclusion by bare name from files under logic/.
 */
`ifndef SFS_CONSTS_VH
`define SFS_CONSTS_VH

// command byte that opens a status read
`define SFS_OPC_STATUS      8'hD7
// bits per byte on the serial line
`define SFS_BITS_PER_BYTE   4'h8
// last bit index inside a byte
`define SFS_LAST_BIT        3'h7

// shared by both status bytes
`define SFS_BIT_READY       7

// first status byte fields
`define SFS_B1_COMP         6
`define SFS_B1_DENS_HI      5
`define SFS_B1_DENS_LO      2
`define SFS_B1_PROTECT      1
`define SFS_B1_PAGE_POW2    0

// second status byte fields
`define SFS_B2_RSVD6        6
`define SFS_B2_OP_FAIL      5
`define SFS_B2_RSVD4        4
`define SFS_B2_LOCK_FEAT    3
`define SFS_B2_BUF2_PAUSE   2
`define SFS_B2_BUF1_PAUSE   1
`define SFS_B2_ERASE_PAUSE  0

// reset values of the serial output drivers
`define SFS_RST_SO          1'b0
`define SFS_RST_SO_OE_N     1'b1

`endif

//--- logic/sfs_sync.v
/*
 * two flip-flop synchroniser for a small group of pin levels.
 * assumes each bit is a slow level relative to core_clk; the first
 * stage is read only by the second stage.
 */
`timescale 1ns/1ps
module sfs_sync #(
  parameter WIDTH = 3
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             reset_n,
  // asynchronous levels in, synchronised levels out
  input  wire [WIDTH-1:0] async_in,
  input  wire [WIDTH-1:0] rst_val,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;   // first stage, feeds sync_out only

  // two stages, reset to the caller's idle levels
  always @(posedge core_clk) begin
    if (!reset_n) begin
      meta_q   <= rst_val;
      sync_out <= rst_val;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

//--- logic/sfs_status_read.v
/*
 * status read engine of a serial flash: takes the command byte on the
 * serial input and streams the two live status bytes on the serial
 * output while chip select stays low.
 * assumes core_clk is well above the serial clock rate, that the pins
 * sck, cs_n and si come from outside core_clk's domain, and that the
 * status inputs come from device logic on core_clk.
 */
//
// Function
// - after command, one status bit per clock
// - after byte two, wrap to byte one
// - status bytes rebuilt live on every pass
// - ready bit in both bytes, sampled per byte
// - select high ends read, output released
// - status read accepted even while busy
// - bit 7 low busy, high ready
// - byte one bit 6 compare mismatch flag
// - byte one bits 5:2 fixed capacity code
// - byte one bit 1 sector protection on
// - byte one bit 0 set for 256-byte pages
// - byte two bit 6 always reads zero
// - byte two bit 5 program/erase error
// - byte two bit 3 lockdown feature enabled
// - byte two bits 1,2 buffer program suspended
// - byte two bit 0 erase suspended
`timescale 1ns/1ps
`include "sfs_consts.vh"
module sfs_status_read #(
  // capacity code; arbitrary neutral value, set per product
  parameter [3:0] DENSITY_CODE = 4'h5
) (
  // clock and reset
  input  wire       core_clk,
  input  wire       reset_n,
  // serial pins from the host
  input  wire       sck,
  input  wire       cs_n,
  input  wire       si,
  // serial output pin, three-state by enable
  output reg        so_out,
  output reg        so_oe_n,
  // live device state, same clock domain
  input  wire       dev_busy,
  input  wire       comp_mismatch,
  input  wire       protect_en,
  input  wire       page_pow2,
  input  wire       op_fail_flag,
  input  wire       lock_feature_flag,
  input  wire       buf_one_prog_paused,
  input  wire       buf_two_prog_paused,
  input  wire       erase_paused_flag,
  // status for the rest of the device
  output reg        stat_read_active,
  output reg        other_cmd_seen
);

  // one-hot states of the command engine
  localparam [3:0] ST_IDLE = 4'b0001;  // select high
  localparam [3:0] ST_CMD  = 4'b0010;  // shifting in the command
  localparam [3:0] ST_STAT = 4'b0100;  // streaming status bytes
  localparam [3:0] ST_SKIP = 4'b1000;  // other command, stay quiet

  // synchronised pin levels
  wire [2:0] pins_sync;              // {cs_n, sck, si} after two flops
  wire       cs_n_s;                 // select, synchronised
  wire       sck_s;                  // serial clock, synchronised
  wire       si_s;                   // serial input, synchronised

  // state
  reg  [3:0] state_q;                // engine state
  reg  [3:0] state_d;
  reg        sck_prev_q;             // serial clock one cycle back
  reg  [7:0] cmd_q;                  // command shift register
  reg  [7:0] cmd_d;
  reg  [3:0] cmd_cnt_q;              // command bits taken
  reg  [3:0] cmd_cnt_d;
  reg  [7:0] shift_q;                // remaining bits of current byte
  reg  [7:0] shift_d;
  reg  [2:0] bit_idx_q;              // bit position in current byte
  reg  [2:0] bit_idx_d;
  reg        byte_sel_q;             // 0 first byte, 1 second byte
  reg        byte_sel_d;
  reg        so_d;
  reg        so_oe_n_d;
  reg        other_d;
  reg  [7:0] load_byte;              // freshly built status byte

  // edges of the synchronised serial clock
  wire       sck_rise = sck_s & ~sck_prev_q;
  wire       sck_fall = ~sck_s & sck_prev_q;

  // assemble one status byte from the live inputs
  function [7:0] build_status;
    input       sel;                 // 0 first byte, 1 second byte
    input       busy;
    input       comp;
    input [3:0] dens;
    input       prot;
    input       pow2;
    input       fail;
    input       lock;
    input       buf2;
    input       buf1;
    input       erp;
    begin
      build_status = 8'h00;
      build_status[`SFS_BIT_READY] = ~busy;
      if (!sel) begin
        build_status[`SFS_B1_COMP] = comp;
        build_status[`SFS_B1_DENS_HI:`SFS_B1_DENS_LO] = dens;
        build_status[`SFS_B1_PROTECT] = prot;
        build_status[`SFS_B1_PAGE_POW2] = pow2;
      end else begin
        build_status[`SFS_B2_RSVD6] = 1'b0;
        build_status[`SFS_B2_RSVD4] = 1'b0;
        build_status[`SFS_B2_OP_FAIL] = fail;
        build_status[`SFS_B2_LOCK_FEAT] = lock;
        build_status[`SFS_B2_BUF2_PAUSE] = buf2;
        build_status[`SFS_B2_BUF1_PAUSE] = buf1;
        build_status[`SFS_B2_ERASE_PAUSE] = erp;
      end
    end
  endfunction

  // pins cross into core_clk through two flops
  sfs_sync #(
    .WIDTH (3)
  ) u_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in ({cs_n, sck, si}),
    .rst_val  (3'h4),
    .sync_out (pins_sync)
  );

  assign cs_n_s = pins_sync[2];
  assign sck_s  = pins_sync[1];
  assign si_s   = pins_sync[0];

  // next-state and datapath decisions
  always @* begin
    state_d    = state_q;
    cmd_d      = cmd_q;
    cmd_cnt_d  = cmd_cnt_q;
    shift_d    = shift_q;
    bit_idx_d  = bit_idx_q;
    byte_sel_d = byte_sel_q;
    so_d       = so_out;
    so_oe_n_d  = so_oe_n;
    other_d    = 1'b0;
    // rebuilt from live inputs each byte
    load_byte  = build_status(byte_sel_q, dev_busy, comp_mismatch,
                              DENSITY_CODE, protect_en, page_pow2,
                              op_fail_flag, lock_feature_flag,
                              buf_two_prog_paused, buf_one_prog_paused,
                              erase_paused_flag);
    // select high ends any phase at once
    if (cs_n_s) begin
      state_d   = ST_IDLE;
      so_d      = `SFS_RST_SO;
      so_oe_n_d = `SFS_RST_SO_OE_N;
    end else begin
      case (state_q)
        // select just fell: start a new command
        ST_IDLE: begin
          state_d    = ST_CMD;
          cmd_cnt_d  = 4'h0;
          bit_idx_d  = 3'h0;
          byte_sel_d = 1'b0;
        end
        // command bits taken on rising edges
        ST_CMD: begin
          if (sck_rise) begin
            cmd_d     = {cmd_q[6:0], si_s};
            cmd_cnt_d = cmd_cnt_q + 4'h1;
            if (cmd_cnt_q == (`SFS_BITS_PER_BYTE - 4'h1)) begin
              // no busy check on this command
              if ({cmd_q[6:0], si_s} == `SFS_OPC_STATUS) begin
                state_d = ST_STAT;
              end else begin
                state_d = ST_SKIP;
                other_d = 1'b1;
              end
            end
          end
        end
        // one status bit per falling edge
        ST_STAT: begin
          if (sck_fall) begin
            so_oe_n_d = 1'b0;
            bit_idx_d = bit_idx_q + 3'h1;
            if (bit_idx_q == 3'h0) begin
              so_d    = load_byte[7];
              shift_d = {load_byte[6:0], 1'b0};
            end else begin
              so_d    = shift_q[7];
              shift_d = {shift_q[6:0], 1'b0};
            end
            if (bit_idx_q == `SFS_LAST_BIT) begin
              byte_sel_d = ~byte_sel_q;
            end
          end
        end
        // other commands are served elsewhere
        ST_SKIP: begin
          state_d = ST_SKIP;
        end
        default: begin
          state_d   = ST_IDLE;
          so_oe_n_d = `SFS_RST_SO_OE_N;
        end
      endcase
    end
  end

  // registers of the engine
  always @(posedge core_clk) begin
    if (!reset_n) begin
      state_q          <= ST_IDLE;
      sck_prev_q       <= 1'b0;
      cmd_q            <= 8'h00;
      cmd_cnt_q        <= 4'h0;
      shift_q          <= 8'h00;
      bit_idx_q        <= 3'h0;
      byte_sel_q       <= 1'b0;
      so_out           <= `SFS_RST_SO;
      so_oe_n          <= `SFS_RST_SO_OE_N;
      stat_read_active <= 1'b0;
      other_cmd_seen   <= 1'b0;
    end else begin
      state_q          <= state_d;
      sck_prev_q       <= sck_s;
      cmd_q            <= cmd_d;
      cmd_cnt_q        <= cmd_cnt_d;
      shift_q          <= shift_d;
      bit_idx_q        <= bit_idx_d;
      byte_sel_q       <= byte_sel_d;
      so_out           <= so_d;
      so_oe_n          <= so_oe_n_d;
      stat_read_active <= (state_d == ST_STAT);
      other_cmd_seen   <= other_d;
    end
  end

endmodule

//--- tb/sfs_host.sv
/* spi host model: one frame per call, mode 0, 160 ns bit time.
   assumes the caller starts it just after a core_clk edge. */
`timescale 1ns/1ps
module sfs_host (
  // pins toward the device
  output reg  sck,
  output reg  cs_n,
  output reg  si,
  // device answer
  input  wire so_out,
  input  wire so_oe_n
);
  reg [31:0] rx;  // bits read, newest in bit 0
  integer    i;   // bit loop
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // frame may stop after any bit
  task frame(input [7:0] cmd, input integer nrd);
    begin
      cs_n = 1'b0;
      #80;
      for (i = 0; i < 8 + nrd; i = i + 1) begin
        // after the command the line toggles, so nothing is read stale
        si = (i < 8) ? cmd[7 - i] : ~si;
        #80;
        if (i >= 8)
          rx = {rx[30:0], so_oe_n ? 1'bx : so_out};
        sck = 1'b1;
        #80;
        sck = 1'b0;
      end
      #80;
      cs_n = 1'b1;
      #80;
    end
  endtask
endmodule

//--- tb/sfs_chk.sv
/* port checker for sfs_status_read, bound below.
   assumes pins change just after a core_clk edge. */
`timescale 1ns/1ps
module sfs_chk #(
  parameter [3:0] DENSITY_CODE = 4'h5
) (
  // clock, reset, pins
  input wire core_clk,
  input wire reset_n,
  input wire sck,
  input wire cs_n,
  input wire so_out,
  input wire so_oe_n,
  // device state and status
  input wire dev_busy,
  input wire comp_mismatch,
  input wire protect_en,
  input wire page_pow2,
  input wire op_fail_flag,
  input wire lock_feature_flag,
  input wire buf_one_prog_paused,
  input wire buf_two_prog_paused,
  input wire erase_paused_flag,
  input wire stat_read_active,
  input wire other_cmd_seen
);
  reg  [3:0]  pos_q;  // bit index within a pass
  reg         sck_q;  // serial clock one cycle ago
  // serial clock fall inside a read
  wire        fall = sck_q & ~sck & ~cs_n & stat_read_active;
  // both bytes, first bit sent at index 15
  wire [15:0] exp_w = {~dev_busy, comp_mismatch, DENSITY_CODE, protect_en,
    page_pow2, ~dev_busy, 1'b0, op_fail_flag, 1'b0, lock_feature_flag,
    buf_two_prog_paused, buf_one_prog_paused, erase_paused_flag};
  // expected bit at the current pass position
  wire        exp_now = exp_w[4'hf - pos_q];
  // follow the bit index of the pass
  always @(posedge core_clk) begin
    sck_q <= sck;
    if (!reset_n || !stat_read_active)
      pos_q <= 4'h0;
    else if (fall)
      pos_q <= pos_q + 4'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  AST_RELEASE: assert property (cs_n [*6] |-> so_oe_n
    && !so_out && !stat_read_active) else $error("output not released");
  AST_START: assert property ($fell(so_oe_n) |-> stat_read_active
    && ($past(fall, 3) || $past(fall, 4))) else $error("early drive");
  AST_TIMING: assert property ($changed(so_out) && !so_oe_n
    && !$past(so_oe_n) |-> $past(fall, 3) || $past(fall, 4))
    else $error("bit off a clock fall");
  AST_BYTE1: assert property (fall && !pos_q[3]
    |-> ##5 so_out == $past(exp_now, 5)) else $error("byte 1");
  AST_BYTE2: assert property (fall && pos_q[3]
    |-> ##5 so_out == $past(exp_now, 5)) else $error("byte 2");
  AST_READY: assert property (fall && pos_q[2:0] == 3'h0
    |-> ##5 so_out == !$past(dev_busy, 5)) else $error("ready bit");
  AST_DENSITY: assert property (fall && pos_q > 4'h1 && pos_q < 4'h6
    |-> ##5 so_out == DENSITY_CODE[4'h5 - $past(pos_q, 5)])
    else $error("capacity code");
  AST_REFUSE: assert property (other_cmd_seen |-> so_oe_n
    ##1 !other_cmd_seen && so_oe_n) else $error("other code answered");
  cover property (fall && pos_q == 4'hf);
  cover property (other_cmd_seen);
  cover property ($rose(so_oe_n));
endmodule
bind sfs_status_read sfs_chk #(.DENSITY_CODE(DENSITY_CODE)) u_sfs_chk (
  .core_clk(core_clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n),
  .so_out(so_out), .so_oe_n(so_oe_n), .dev_busy(dev_busy),
  .comp_mismatch(comp_mismatch), .protect_en(protect_en),
  .page_pow2(page_pow2), .op_fail_flag(op_fail_flag),
  .lock_feature_flag(lock_feature_flag),
  .buf_one_prog_paused(buf_one_prog_paused),
  .buf_two_prog_paused(buf_two_prog_paused),
  .erase_paused_flag(erase_paused_flag),
  .stat_read_active(stat_read_active), .other_cmd_seen(other_cmd_seen));

//--- tb/testbench.sv
/* self-checking bench for the status read engine.
   assumes the host model and the bound checker. */
`timescale 1ns/1ps
module testbench;
  localparam [3:0] DENS = 4'ha;  // capacity code for this run
  reg        core_clk = 1'b0;    // 100 MHz clock
  reg        reset_n = 1'b0;     // synchronous reset
  reg        dev_busy = 1'b1;    // internal operation running
  reg  [7:0] fl = 8'h00;         // status flags
  wire       sck, cs_n, si, so_out, so_oe_n, act, oth;
  integer    errors = 0;
  integer    n_compared = 0;
  integer    n_oth = 0;          // refused command pulses
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (oth === 1'b1) n_oth <= n_oth + 1;
  sfs_status_read #(.DENSITY_CODE(DENS)) u_sfs_status_read (
    .core_clk(core_clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n),
    .si(si), .so_out(so_out), .so_oe_n(so_oe_n), .dev_busy(dev_busy),
    .comp_mismatch(fl[0]), .protect_en(fl[1]), .page_pow2(fl[2]),
    .op_fail_flag(fl[3]), .lock_feature_flag(fl[4]),
    .buf_two_prog_paused(fl[5]), .buf_one_prog_paused(fl[6]),
    .erase_paused_flag(fl[7]), .stat_read_active(act),
    .other_cmd_seen(oth));
  sfs_host u_sfs_host (.sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out),
    .so_oe_n(so_oe_n));
  task check(input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
    end
  endtask
  // both status bytes as the host should see them
  function [15:0] stat(input b);
    stat = {~b, fl[0], DENS, fl[1], fl[2], ~b, 1'b0, fl[3], 1'b0, fl[4],
      fl[5], fl[6], fl[7]};
  endfunction
  // two passes per frame, every flag both ways
  task t_stream;
    integer p;
    begin
      for (p = 0; p < 2; p = p + 1) begin
        dev_busy = p[0];
        // neighbouring flags differ except fl[3] and fl[4], each flag seen both ways
        fl = p[0] ? 8'h5a : 8'ha5;
        u_sfs_host.frame(8'hD7, 32);
        check(u_sfs_host.rx, {2{stat(p[0])}});
      end
    end
  endtask
  // busy ends during byte one of a running read
  task t_busy;
    reg [15:0] s0;
    reg [15:0] s1;
    begin
      dev_busy = 1'b1;
      s0 = stat(1'b1);
      fork
        u_sfs_host.frame(8'hD7, 24);
        #1860 dev_busy = 1'b0;
      join
      s1 = stat(1'b0);
      // byte one busy, then byte two and byte one ready
      check(u_sfs_host.rx[23:0], {s0[15:8], s1[7:0], s1[15:8]});
    end
  endtask
  // read cut inside byte two, next read restarts at byte one
  task t_abort;
    reg [15:0] s0;
    begin
      u_sfs_host.frame(8'hD7, 11);
      check({so_oe_n, so_out, act}, 3'h4);
      s0 = stat(dev_busy);
      u_sfs_host.frame(8'hD7, 8);
      check(u_sfs_host.rx[7:0], s0[15:8]);
    end
  endtask
  // codes one bit away from the read code stay unanswered
  task t_refuse;
    begin
      u_sfs_host.frame(8'hD6, 8);
      u_sfs_host.frame(8'h57, 8);
      check(u_sfs_host.rx[15:0], 16'hxxxx);
      check(n_oth, 2);
    end
  endtask
  task final_report;
    begin
      if (errors == 0 && n_compared > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    check({so_oe_n, so_out, act}, 3'h4);
    t_stream;
    t_busy;
    t_abort;
    t_refuse;
    final_report;
  end
  // hang guard, runs take about 30 us
  initial begin
    #300000;
    errors = errors + 1;
    final_report;
  end
endmodule
